// ===== include/drive_supv_pkg.sv
package drive_supv_pkg;

  // Register byte addresses (AXI4-Lite, one word each)
  localparam logic [7:0] ADDR_ERROR_ACTION = 8'h00;
  localparam logic [7:0] ADDR_LOSS_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_ACCEL_THRESH = 8'h08;
  localparam logic [7:0] ADDR_DECEL_THRESH = 8'h0C;
  localparam logic [7:0] ADDR_FUNC_SELECT  = 8'h10;
  localparam logic [7:0] ADDR_MAP_SELECT   = 8'h14;
  localparam logic [7:0] ADDR_STATUS       = 8'h18;
  localparam logic [7:0] ADDR_WRITE_MAP0   = 8'h40;
  localparam logic [7:0] ADDR_READ_MAP0    = 8'h68;
  localparam int         MAP_SLOTS         = 10;

  // Field positions
  localparam int CW_HOLD_BIT    = 5;
  localparam int SW_ARRIVAL_BIT = 10;
  localparam int FS_IN5_LSB     = 0;
  localparam int FS_IN6_LSB     = 8;
  localparam int FS_RESET_LSB   = 16;
  localparam int FS_JOG_LSB     = 20;
  localparam int FS_LOCK_LSB    = 24;

  // Codes and reset values
  localparam logic [7:0]  IN5_SECOND_STAGE  = 8'h09;
  localparam logic [7:0]  IN6_RAMP_HOLD     = 8'h53;
  localparam logic [7:0]  LOCK_RUN_EDIT     = 8'h0A;
  localparam logic [3:0]  RESET_SEL_TRIP    = 4'h3;
  localparam logic [15:0] LOSS_TIMEOUT_RST  = 16'h0064;
  localparam logic [31:0] FUNC_SELECT_RST   = 32'h0140_1209;
  localparam logic [15:0] OPTION_ERROR_CODE = 16'h003C;

  // Loss timer tick: 10 ms per count at 100 MHz
  localparam int CLK_MHZ     = 100;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;

  typedef enum logic [2:0] {
    ACT_TRIP, ACT_DECEL_TRIP, ACT_IGNORE, ACT_COAST, ACT_DECEL
  } err_action_t;

  typedef enum logic [1:0] {STOP_COAST, STOP_DECEL, STOP_DCBRAKE} jog_stop_t;

  typedef enum logic [1:0] {AXI_IDLE, AXI_WRESP, AXI_RRESP} axi_state_t;

  typedef enum logic [1:0] {LOSS_IDLE, LOSS_TIMING, LOSS_DONE} loss_state_t;

endpackage

// ===== test/drive_comm_supervision_assertions.sv
`timescale 1ns/1ps
module drive_comm_supervision_assertions #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        fieldbus_watchdog,
  input wire logic        cyclic_exchange_ok,
  input wire logic [15:0] drive_control_word,
  input wire logic        jog_request,
  input wire logic        profile_operation,
  input wire logic        quick_stop,
  input wire logic        accelerating,
  input wire logic        decelerating,
  input wire logic        reset_terminal,
  input wire logic        comm_error_event,
  input wire logic [2:0]  comm_error_reaction,
  input wire logic        trip_active,
  input wire logic        option_reset,
  input wire logic [15:0] display_error_code,
  input wire logic        freq_arrival,
  input wire logic        ramp_hold,
  input wire logic        use_second_decel,
  input wire logic        jog_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // Loss event is a lone pulse, only after watchdog with exchange down
  AST_EVT_ONCE: assert property (comm_error_event |=> !comm_error_event [*8])
    else $error("loss event repeated");
  AST_EVT_CAUSE: assert property (comm_error_event |-> $past(fieldbus_watchdog) && !$past(cyclic_exchange_ok))
    else $error("loss event without watchdog");
  AST_ABANDON: assert property (cyclic_exchange_ok [*2] |=> !comm_error_event)
    else $error("loss event while exchange runs");
  AST_TRIP: assert property (comm_error_event && comm_error_reaction != 3'd2 |-> ##[0:1] trip_active)
    else $error("trip not raised on loss");
  // Option reset follows the terminal and shows the option code
  AST_OPT_RST: assert property (option_reset |-> $past(reset_terminal) ##[0:1] display_error_code == 16'h003C)
    else $error("option reset without terminal");
  // Status levels trace their one-cycle-old causes
  AST_JOG: assert property (jog_active |-> $past(jog_request) && $past(profile_operation))
    else $error("jog outside operation");
  AST_HOLD: assert property (ramp_hold |-> !$past(drive_control_word[drive_supv_pkg::CW_HOLD_BIT]))
    else $error("hold with control bit set");
  AST_ARRIVE: assert property (freq_arrival |-> $past(accelerating) || $past(decelerating))
    else $error("arrival outside ramp");
  AST_QSTOP: assert property (use_second_decel |-> $past(quick_stop))
    else $error("second decel without quick stop");
endmodule

bind drive_comm_supervision drive_comm_supervision_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk, .resetn, .fieldbus_watchdog, .cyclic_exchange_ok, .drive_control_word, .jog_request,
  .profile_operation, .quick_stop, .accelerating, .decelerating, .reset_terminal, .comm_error_event,
  .comm_error_reaction, .trip_active, .option_reset, .display_error_code, .freq_arrival, .ramp_hold,
  .use_second_decel, .jog_active
);

// ===== test/fieldbus_ctrl_model.sv
`timescale 1ns/1ps
module fieldbus_ctrl_model #(
  parameter int WD_CYCLES = 3
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        link_up,
  input  wire logic        hold_req,
  input  wire logic        jog_req,
  input  wire logic        qstop_req,
  input  wire logic        wr_req,
  input  wire logic [15:0] wr_val,
  output logic             fieldbus_watchdog,
  output logic             cyclic_exchange_ok,
  output logic [15:0]      drive_control_word,
  output logic             jog_request,
  output logic             profile_operation,
  output logic             quick_stop,
  output logic             param_write,
  output logic [15:0]      param_write_data
);
  int silent;

  // Stale words toggle while silent, so no old value passes for fresh
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      silent <= 0;
      {fieldbus_watchdog, cyclic_exchange_ok, jog_request, profile_operation} <= '0;
      {quick_stop, param_write, drive_control_word, param_write_data} <= '0;
    end else begin
      silent <= link_up ? 0 : silent + 1;
      fieldbus_watchdog <= !link_up && silent >= WD_CYCLES - 1;
      cyclic_exchange_ok <= link_up;
      // Run command only from this controller
      drive_control_word <= link_up ? (hold_req ? 16'h045F : 16'h047F) : ~drive_control_word;
      jog_request <= link_up && jog_req;
      profile_operation <= link_up;
      quick_stop <= qstop_req;
      param_write <= link_up && wr_req;
      param_write_data <= wr_req ? wr_val : ~param_write_data;
    end
  end
endmodule

// ===== test/tb_drive_comm_supervision.sv
`timescale 1ns/1ps
module tb_drive_comm_supervision;
  logic        core_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, param_write;
  logic        fieldbus_watchdog, cyclic_exchange_ok, jog_request, profile_operation, quick_stop;
  logic        drive_running, accelerating, decelerating, reset_terminal, comm_error_event;
  logic        trip_active, option_reset, freq_arrival, ramp_hold, use_second_decel, jog_active;
  logic        link_up, hold_req, jog_req, qstop_req, wr_req;
  logic [1:0]  s_axi_bresp, s_axi_rresp, jog_stop_kind;
  logic [2:0]  comm_error_reaction;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [15:0] drive_control_word, param_write_data, output_frequency, jog_frequency, wr_val;
  logic [15:0] display_error_code, jog_setpoint, applied_param;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_errors, num_checks, n_evt, n_orst, ne, t;

  drive_comm_supervision #(.TICK_CYCLES(4)) u_dut (.*);
  fieldbus_ctrl_model u_ctrl (
    .core_clk, .resetn, .link_up, .hold_req, .jog_req, .qstop_req, .wr_req, .wr_val, .fieldbus_watchdog,
    .cyclic_exchange_ok, .drive_control_word, .jog_request, .profile_operation, .quick_stop,
    .param_write, .param_write_data
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Non-blocking, so readers at the same edge see the old count
  always @(posedge core_clk) begin
    if (comm_error_event === 1'b1) n_evt <= n_evt + 1;
    if (option_reset === 1'b1) n_orst <= n_orst + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Offer address and data together, drop each once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write_response", 32'h4, {s_axi_bvalid, s_axi_bresp});
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(nm, e, d);
  endtask

  // Lock mode, jog stop code, reset selection, input six and five codes
  function automatic logic [31:0] fsel(input logic [3:0] jg, input logic [3:0] rs, input logic [7:0] i5,
                                       input logic [7:0] i6, input logic [7:0] lk);
    return {lk, jg, rs, i6, i5};
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    test_done();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, wr_req} = '0;
    {drive_running, accelerating, decelerating, reset_terminal, hold_req, jog_req, qstop_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, output_frequency, wr_val} = '0;
    s_axi_wstrb = 4'hF;
    jog_frequency = 16'h0123;
    link_up = 1'b1;
    cyc(8);
    resetn <= 1'b1;
    rdc("action_reset", drive_supv_pkg::ADDR_ERROR_ACTION, 16'h0000);
    rdc("loss_reset", drive_supv_pkg::ADDR_LOSS_TIMEOUT, 16'h0064);
    rdc("wmap_reset", drive_supv_pkg::ADDR_WRITE_MAP0 + 8'h24, 16'h0000);
    rdc("rmap_reset", drive_supv_pkg::ADDR_READ_MAP0, 16'h0000);
    rdc("mapsel_reset", drive_supv_pkg::ADDR_MAP_SELECT, 16'h0000);
    axw(drive_supv_pkg::ADDR_READ_MAP0 + 8'h24, 32'h0001_FFFF);
    rdc("rmap_full", drive_supv_pkg::ADDR_READ_MAP0 + 8'h24, 16'hFFFF);
    axw(drive_supv_pkg::ADDR_ERROR_ACTION, 16'h0005);
    rdc("action_bad", drive_supv_pkg::ADDR_ERROR_ACTION, 16'h0000);
    axw(drive_supv_pkg::ADDR_LOSS_TIMEOUT, 16'h2710);
    rdc("loss_clamp", drive_supv_pkg::ADDR_LOSS_TIMEOUT, 16'h270F);
    axr(8'hFC, d, r);
    chk("unmapped_resp", 2'h2, r);
    // Jog code 0 stays off every input; reset selection clears trip and error code only
    axw(drive_supv_pkg::ADDR_FUNC_SELECT, fsel(4'h0, 4'h3, 8'h09, 8'h53, 8'h0A));
    axw(drive_supv_pkg::ADDR_LOSS_TIMEOUT, 16'h0003);
    for (int a = 0; a < 5; a++) begin
      axw(drive_supv_pkg::ADDR_ERROR_ACTION, 32'(a));
      ne = n_evt;
      link_up <= 1'b0;
      t = 0;
      while (n_evt == ne && t < 100) begin
        @(posedge core_clk);
        t++;
      end
      cyc(12);
      chk("loss_delay", 1, t >= 10 && t <= 30);
      chk("event_once", ne + 1, n_evt);
      chk("reaction", a, comm_error_reaction);
      chk("trip", a != 2, trip_active);
      link_up <= 1'b1;
      reset_terminal <= 1'b1;
      cyc(1);
      reset_terminal <= 1'b0;
      cyc(3);
      chk("trip_clear", 0, trip_active);
    end
    ne = n_evt;
    link_up <= 1'b0;
    cyc(5);
    link_up <= 1'b1;
    cyc(40);
    chk("abandon", ne, n_evt);
    axw(drive_supv_pkg::ADDR_LOSS_TIMEOUT, 16'h0000);
    link_up <= 1'b0;
    cyc(60);
    link_up <= 1'b1;
    cyc(3);
    chk("zero_disables", ne, n_evt);
    for (int j = 0; j < 6; j++) begin
      axw(drive_supv_pkg::ADDR_FUNC_SELECT, fsel(4'(j), 4'h3, 8'h09, 8'h53, 8'h0A));
      cyc(2);
      chk("jog_stop", j % 3, jog_stop_kind);
    end
    {hold_req, qstop_req, jog_req} <= 3'h7;
    cyc(4);
    chk("ramp_hold", 1, ramp_hold);
    chk("second_decel", 1, use_second_decel);
    chk("jog_active", 1, jog_active);
    chk("jog_setpoint", 16'h0123, jog_setpoint);
    axw(drive_supv_pkg::ADDR_FUNC_SELECT, fsel(4'h0, 4'h3, 8'h08, 8'h12, 8'h0A));
    cyc(2);
    chk("no_hold", 0, ramp_hold);
    chk("normal_decel", 0, use_second_decel);
    {hold_req, qstop_req, jog_req} <= 3'h0;
    for (int k = 0; k < 4; k++) begin
      axw(k < 2 ? drive_supv_pkg::ADDR_ACCEL_THRESH : drive_supv_pkg::ADDR_DECEL_THRESH, k % 2 ? 16'h1000 : 16'h0000);
      accelerating <= (k < 2);
      decelerating <= (k >= 2);
      output_frequency <= 16'hC000;
      cyc(3);
      chk("arrival", k % 2, freq_arrival);
    end
    drive_running <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      axw(drive_supv_pkg::ADDR_FUNC_SELECT, fsel(4'h0, 4'h3, 8'h08, 8'h12, p ? 8'h01 : 8'h0A));
      wr_val <= p ? 16'hA5A5 : 16'h5A5A;
      wr_req <= 1'b1;
      cyc(1);
      wr_req <= 1'b0;
      cyc(3);
      chk("applied_param", 16'h5A5A, applied_param);
    end
    for (int s = 0; s < 4; s++) begin
      axw(drive_supv_pkg::ADDR_FUNC_SELECT, fsel(4'h0, 4'(s), 8'h09, 8'h53, 8'h0A));
      ne = n_orst;
      reset_terminal <= 1'b1;
      cyc(1);
      reset_terminal <= 1'b0;
      cyc(3);
      chk("option_reset", ne + (s < 3), n_orst);
      chk("error_code", s < 3 ? 16'h003C : 16'h0000, display_error_code);
    end
    test_done();
  end
endmodule

// ===== verilog/drive_comm_supervision.sv
`timescale 1ns/1ps
// How it works
// - Communication error reaction chosen by error action code 0..4, reset 0
// - Loss supervision time 0.00..99.99 s in 10 ms units, default 1.00 s
// - Loss timer starts only after the fieldbus watchdog has fired
// - Resumed cyclic exchange before expiry abandons the pending timeout
// - A supervision time of zero disables loss monitoring
// - While accelerating set status bit 10 above accel threshold
// - Accel threshold zero never sets status bit 10
// - While decelerating set status bit 10 above decel threshold
// - Decel threshold zero never sets status bit 10
// - Control bit 5 off holds frequency only if input six is hold code
// - Reset selection 0..2: reset terminal resets option, shows option error
// - Reset selection 3: reset terminal clears trip and error code only, option keeps running
// - Jog stop codes 0,1,2 act as 3,4,5
// - Frequency is a signed fraction of full scale, -100% to 100%
// - Jog runs at jog frequency while the profile is in operation
// - Quick stop uses second decel time only if input five is code 9
// - Fieldbus parameter writes apply during run only with lock mode 10
// - Ten write and ten read map slots, 16 bits each, reset 0
module drive_comm_supervision #(
  parameter int TICK_CYCLES = drive_supv_pkg::TICK_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Fieldbus side
  input  wire logic        fieldbus_watchdog,
  input  wire logic        cyclic_exchange_ok,
  input  wire logic [15:0] drive_control_word,
  input  wire logic        jog_request,
  input  wire logic        profile_operation,
  input  wire logic        quick_stop,
  input  wire logic        param_write,
  input  wire logic [15:0] param_write_data,
  input  wire logic        drive_running,
  // Drive core side
  input  wire logic [15:0] output_frequency,
  input  wire logic        accelerating,
  input  wire logic        decelerating,
  input  wire logic        reset_terminal,
  input  wire logic [15:0] jog_frequency,
  output logic             comm_error_event,
  output logic [2:0]       comm_error_reaction,
  output logic             trip_active,
  output logic             option_reset,
  output logic [15:0]      display_error_code,
  output logic             freq_arrival,
  output logic             ramp_hold,
  output logic             use_second_decel,
  output logic             jog_active,
  output logic [15:0]      jog_setpoint,
  output logic [1:0]       jog_stop_kind,
  output logic [15:0]      applied_param
);

  localparam int MAP_SLOTS_W = drive_supv_pkg::MAP_SLOTS;

  typedef struct packed {
    drive_supv_pkg::axi_state_t  axi;
    logic                        aw_got;
    logic                        w_got;
    logic [7:0]                  waddr;
    logic [31:0]                 wdata;
    logic [1:0]                  bresp;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    logic [2:0]                  err_action;
    logic [15:0]                 loss_timeout;
    logic [15:0]                 accel_thresh;
    logic [15:0]                 decel_thresh;
    logic [31:0]                 func_select;
    logic [15:0]                 map_select;
    logic [MAP_SLOTS_W-1:0][15:0] wmap;
    logic [MAP_SLOTS_W-1:0][15:0] rmap;
    drive_supv_pkg::loss_state_t loss;
    logic [31:0]                 tick_cnt;
    logic [15:0]                 loss_cnt;
    logic                        err_event;
    logic [2:0]                  reaction;
    logic                        trip;
    logic                        opt_reset;
    logic [15:0]                 err_code;
    logic                        arrival;
    logic                        hold;
    logic                        second_decel;
    logic                        jog;
    logic [15:0]                 jog_set;
    logic [1:0]                  jog_stop;
    logic [15:0]                 param;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [7:0]  in5_func;
  logic [7:0]  in6_func;
  logic [3:0]  reset_sel;
  logic [3:0]  jog_code;
  logic [7:0]  lock_mode;
  logic        tick;
  logic [7:0]  widx;
  logic [7:0]  ridx;
  logic [31:0] wmask;
  logic [31:0] rd_word;

  assign in5_func  = st_r.func_select[drive_supv_pkg::FS_IN5_LSB +: 8];
  assign in6_func  = st_r.func_select[drive_supv_pkg::FS_IN6_LSB +: 8];
  assign reset_sel = st_r.func_select[drive_supv_pkg::FS_RESET_LSB +: 4];
  assign jog_code  = st_r.func_select[drive_supv_pkg::FS_JOG_LSB +: 4];
  assign lock_mode = st_r.func_select[drive_supv_pkg::FS_LOCK_LSB +: 8];
  assign tick      = (st_r.tick_cnt == 32'(TICK_CYCLES - 1));
  assign widx      = 8'((st_r.waddr - drive_supv_pkg::ADDR_WRITE_MAP0) >> 2);
  assign ridx      = 8'((s_axi_araddr - drive_supv_pkg::ADDR_WRITE_MAP0) >> 2);

  // Byte lane mask from write strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  // Read decode; unmapped addresses read zero, with a slave error only above the status address
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == drive_supv_pkg::ADDR_ERROR_ACTION) begin
      rd_word = {29'h0000_0000, st_r.err_action};
    end else if (s_axi_araddr == drive_supv_pkg::ADDR_LOSS_TIMEOUT) begin
      rd_word = {16'h0000, st_r.loss_timeout};
    end else if (s_axi_araddr == drive_supv_pkg::ADDR_ACCEL_THRESH) begin
      rd_word = {16'h0000, st_r.accel_thresh};
    end else if (s_axi_araddr == drive_supv_pkg::ADDR_DECEL_THRESH) begin
      rd_word = {16'h0000, st_r.decel_thresh};
    end else if (s_axi_araddr == drive_supv_pkg::ADDR_FUNC_SELECT) begin
      rd_word = st_r.func_select;
    end else if (s_axi_araddr == drive_supv_pkg::ADDR_MAP_SELECT) begin
      rd_word = {16'h0000, st_r.map_select};
    end else if (s_axi_araddr == drive_supv_pkg::ADDR_STATUS) begin
      rd_word = {24'h0000_00, st_r.trip, st_r.opt_reset, st_r.arrival, st_r.jog,
                 st_r.hold, st_r.reaction};
    end else if (ridx < 8'(2 * MAP_SLOTS_W) && s_axi_araddr[1:0] == 2'b00) begin
      rd_word = (ridx < 8'(MAP_SLOTS_W)) ? {16'h0000, st_r.wmap[ridx]}
                                         : {16'h0000, st_r.rmap[8'(ridx - 8'(MAP_SLOTS_W))]};
    end
  end

  always_comb begin
    st_nxt           = st_r;
    st_nxt.err_event = 1'b0;

    // AXI4-Lite slave: address and data accepted in either order
    unique case (st_r.axi)
      drive_supv_pkg::AXI_IDLE: begin
        if (s_axi_awvalid && !st_r.aw_got) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_got) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata & wmask;
        end
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.bresp  = 2'b00;
          st_nxt.axi    = drive_supv_pkg::AXI_WRESP;
          if (st_r.waddr == drive_supv_pkg::ADDR_ERROR_ACTION) begin
            st_nxt.err_action = (st_r.wdata[2:0] <= 3'(drive_supv_pkg::ACT_DECEL))
                                ? st_r.wdata[2:0] : st_r.err_action;
          end else if (st_r.waddr == drive_supv_pkg::ADDR_LOSS_TIMEOUT) begin
            st_nxt.loss_timeout = (st_r.wdata[15:0] <= 16'h270F)
                                  ? st_r.wdata[15:0] : 16'h270F;
          end else if (st_r.waddr == drive_supv_pkg::ADDR_ACCEL_THRESH) begin
            st_nxt.accel_thresh = st_r.wdata[15:0];
          end else if (st_r.waddr == drive_supv_pkg::ADDR_DECEL_THRESH) begin
            st_nxt.decel_thresh = st_r.wdata[15:0];
          end else if (st_r.waddr == drive_supv_pkg::ADDR_FUNC_SELECT) begin
            st_nxt.func_select = st_r.wdata;
          end else if (st_r.waddr == drive_supv_pkg::ADDR_MAP_SELECT) begin
            st_nxt.map_select = st_r.wdata[15:0];
          end else if (widx < 8'(2 * MAP_SLOTS_W) && st_r.waddr[1:0] == 2'b00) begin
            if (widx < 8'(MAP_SLOTS_W)) begin
              st_nxt.wmap[widx] = st_r.wdata[15:0];
            end else begin
              st_nxt.rmap[8'(widx - 8'(MAP_SLOTS_W))] = st_r.wdata[15:0];
            end
          end else if (st_r.waddr != drive_supv_pkg::ADDR_STATUS) begin
            st_nxt.bresp = 2'b10;
          end
        end else if (s_axi_arvalid && !st_r.aw_got && !st_r.w_got) begin
          st_nxt.rdata = rd_word;
          st_nxt.rresp = (rd_word == 32'h0000_0000 && s_axi_araddr > drive_supv_pkg::ADDR_STATUS
                          && !(ridx < 8'(2 * MAP_SLOTS_W) && s_axi_araddr[1:0] == 2'b00))
                         ? 2'b10 : 2'b00;
          st_nxt.axi   = drive_supv_pkg::AXI_RRESP;
        end
      end
      drive_supv_pkg::AXI_WRESP: begin
        if (s_axi_bready) begin
          st_nxt.axi = drive_supv_pkg::AXI_IDLE;
        end
      end
      drive_supv_pkg::AXI_RRESP: begin
        if (s_axi_rready) begin
          st_nxt.axi = drive_supv_pkg::AXI_IDLE;
        end
      end
      default: st_nxt.axi = drive_supv_pkg::AXI_IDLE;
    endcase

    // 10 ms timebase for the loss timer
    st_nxt.tick_cnt = tick ? 32'h0000_0000 : st_r.tick_cnt + 32'h0000_0001;

    // Communication loss timer, separate from the protocol watchdog
    unique case (st_r.loss)
      drive_supv_pkg::LOSS_IDLE: begin
        st_nxt.loss_cnt = 16'h0000;
        if (fieldbus_watchdog && st_r.loss_timeout != 16'h0000) begin
          st_nxt.loss = drive_supv_pkg::LOSS_TIMING;
        end
      end
      drive_supv_pkg::LOSS_TIMING: begin
        if (cyclic_exchange_ok || st_r.loss_timeout == 16'h0000) begin
          st_nxt.loss = drive_supv_pkg::LOSS_IDLE;
        end else if (tick) begin
          st_nxt.loss_cnt = st_r.loss_cnt + 16'h0001;
          if (st_r.loss_cnt + 16'h0001 >= st_r.loss_timeout) begin
            st_nxt.loss      = drive_supv_pkg::LOSS_DONE;
            st_nxt.err_event = 1'b1;
            st_nxt.reaction  = st_r.err_action;
            if (st_r.err_action != 3'(drive_supv_pkg::ACT_IGNORE)) begin
              st_nxt.trip = 1'b1;
            end
          end
        end
      end
      drive_supv_pkg::LOSS_DONE: begin
        // Held until link is back or an option reset sends it to idle, so the action fires once per hold
        if (cyclic_exchange_ok) begin
          st_nxt.loss = drive_supv_pkg::LOSS_IDLE;
        end
      end
      default: st_nxt.loss = drive_supv_pkg::LOSS_IDLE;
    endcase

    // Reset terminal behaviour
    st_nxt.opt_reset = 1'b0;
    if (reset_terminal) begin
      // An expiry in the same cycle wins over the clear
      st_nxt.trip = st_nxt.err_event && (st_r.err_action != 3'(drive_supv_pkg::ACT_IGNORE));
      if (reset_sel == drive_supv_pkg::RESET_SEL_TRIP) begin
        st_nxt.err_code = 16'h0000;
      end else begin
        st_nxt.opt_reset = 1'b1;
        st_nxt.err_code  = drive_supv_pkg::OPTION_ERROR_CODE;
        st_nxt.loss      = drive_supv_pkg::LOSS_IDLE;
      end
    end

    // Frequency arrival flag; magnitude of signed fraction compared
    st_nxt.arrival = 1'b0;
    if (accelerating && st_r.accel_thresh != 16'h0000 &&
        (output_frequency[15] ? 16'(-output_frequency) : output_frequency) > st_r.accel_thresh) begin
      st_nxt.arrival = 1'b1;
    end
    if (decelerating && st_r.decel_thresh != 16'h0000 &&
        (output_frequency[15] ? 16'(-output_frequency) : output_frequency) > st_r.decel_thresh) begin
      st_nxt.arrival = 1'b1;
    end

    // Ramp hold and quick-stop ramp selection
    st_nxt.hold = !drive_control_word[drive_supv_pkg::CW_HOLD_BIT] &&
                  (in6_func == drive_supv_pkg::IN6_RAMP_HOLD);
    st_nxt.second_decel = quick_stop && (in5_func == drive_supv_pkg::IN5_SECOND_STAGE);

    // Jog only in operation state; codes 0..2 fold onto 3..5
    st_nxt.jog     = jog_request && profile_operation;
    st_nxt.jog_set = (jog_request && profile_operation) ? jog_frequency : 16'h0000;
    st_nxt.jog_stop = (jog_code >= 4'h3) ? 2'(jog_code - 4'h3) : jog_code[1:0];

    // Fieldbus parameter writes gated by lock mode while running
    if (param_write && (!drive_running || lock_mode == drive_supv_pkg::LOCK_RUN_EDIT)) begin
      st_nxt.param = param_write_data;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r              <= '0;
      st_r.loss_timeout <= drive_supv_pkg::LOSS_TIMEOUT_RST;
      st_r.func_select  <= drive_supv_pkg::FUNC_SELECT_RST;
      st_r.jog_stop     <= 2'(drive_supv_pkg::STOP_DECEL);
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready       = (st_r.axi == drive_supv_pkg::AXI_IDLE) && !st_r.aw_got;
  assign s_axi_wready        = (st_r.axi == drive_supv_pkg::AXI_IDLE) && !st_r.w_got;
  assign s_axi_bvalid        = (st_r.axi == drive_supv_pkg::AXI_WRESP);
  assign s_axi_bresp         = st_r.bresp;
  assign s_axi_arready       = (st_r.axi == drive_supv_pkg::AXI_IDLE) && !st_r.aw_got && !st_r.w_got;
  assign s_axi_rvalid        = (st_r.axi == drive_supv_pkg::AXI_RRESP);
  assign s_axi_rdata         = st_r.rdata;
  assign s_axi_rresp         = st_r.rresp;
  assign comm_error_event    = st_r.err_event;
  assign comm_error_reaction = st_r.reaction;
  assign trip_active         = st_r.trip;
  assign option_reset        = st_r.opt_reset;
  assign display_error_code  = st_r.err_code;
  assign freq_arrival        = st_r.arrival;
  assign ramp_hold           = st_r.hold;
  assign use_second_decel    = st_r.second_decel;
  assign jog_active          = st_r.jog;
  assign jog_setpoint        = st_r.jog_set;
  assign jog_stop_kind       = st_r.jog_stop;
  assign applied_param       = st_r.param;

endmodule
